// ==== pkg/stc_pkg.sv ====
/*
 Constants and types for the 16-bit timer/event counter block.
 Assumes a 32-bit AXI4-Lite slave where each register index maps to byte address index*4.
*/
package stc_pkg;

    localparam int IDX_W   = 18;
    localparam int N_TIMER = 2;
    localparam int IRQ_W   = 3 * N_TIMER;

    // Register indices, timer0 first
    localparam logic [IDX_W-1:0] IDX_MODE  [N_TIMER] = '{18'h0FFBA, 18'h0FFB6};
    localparam logic [IDX_W-1:0] IDX_PRESC [N_TIMER] = '{18'h0FFBB, 18'h0FFB7};
    localparam logic [IDX_W-1:0] IDX_CAPT  [N_TIMER] = '{18'h0FFBC, 18'h0FFB8};
    localparam logic [IDX_W-1:0] IDX_OUTC  [N_TIMER] = '{18'h0FFBD, 18'h0FFB9};
    localparam logic [IDX_W-1:0] IDX_COUNT [N_TIMER] = '{18'h0FFC0, 18'h0FFB0};
    localparam logic [IDX_W-1:0] IDX_CMPA  [N_TIMER] = '{18'h0FFC1, 18'h0FFB2};
    localparam logic [IDX_W-1:0] IDX_CMPB  [N_TIMER] = '{18'h0FFC2, 18'h0FFB4};
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 18'h0FFC4;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 18'h0FFC5;

    // Field positions
    localparam int MODE_OVF_BIT = 0;
    localparam int MODE_TOG_BIT = 1;
    localparam int MODE_RUN_LO  = 2;
    localparam int PRM_DIV_LO   = 0;
    localparam int PRM_ES_LO    = 4;
    localparam int OUTC_EN_BIT  = 0;

    // Reset values
    localparam logic [7:0]       BYTE_RST = 8'h00;
    localparam logic [15:0]      WORD_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST  = 6'h00;
    localparam logic [15:0]      CNT_MAX  = 16'hFFFF;

    // Prescaler limits for count clock divide by 1, 4, 16, 256
    localparam logic [7:0] DIV1_MAX   = 8'h00;
    localparam logic [7:0] DIV4_MAX   = 8'h03;
    localparam logic [7:0] DIV16_MAX  = 8'h0F;
    localparam logic [7:0] DIV256_MAX = 8'hFF;

    // Variant gate for the second timer
    localparam int T1_MIN_FLASH_KB = 48;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {RUN_STOP, RUN_FREE, RUN_TRIG, RUN_MATCH} stc_run_e;
    typedef enum logic [1:0] {ES_FALL, ES_RISE, ES_NONE, ES_BOTH} stc_edge_e;

endpackage

// ==== design/stc_timer_core.sv ====
/*
 One 16-bit timer/event counter: prescaler, counter, trigger edge detect,
 compare matches, overflow flag and toggle output.
 Assumes control inputs come from registers in the same clock domain.
*/
module stc_timer_core
    import stc_pkg::*;
(
    input  wire logic     clock_i,
    input  wire logic     sys_rst_i,
    input  wire stc_run_e run_mode_i,
    input  wire logic     toggle_cond_i,
    input  wire logic [7:0]  presc_i,
    input  wire logic [15:0] cmpa_i,
    input  wire logic [15:0] cmpb_i,
    input  wire logic     trigger_input_pin_i,
    input  wire logic     ovf_set_i,
    input  wire logic     ovf_clr_i,
    output logic [15:0]   count_o,
    output logic          ovf_flag_o,
    output logic          timer_output_pin_o,
    output logic          overflow_o,
    output logic          match_a_o,
    output logic          match_b_o
);

    function automatic logic [7:0] div_limit(input logic [1:0] sel);
        unique case (sel)
            2'h0: div_limit = DIV1_MAX;
            2'h1: div_limit = DIV4_MAX;
            2'h2: div_limit = DIV16_MAX;
            2'h3: div_limit = DIV256_MAX;
        endcase
    endfunction

    logic [7:0]  div_r;
    logic        trig_prev_r;
    logic [15:0] count_nxt;

    wire stc_edge_e edge_sel = stc_edge_e'(presc_i[PRM_ES_LO +: 2]);
    wire running   = (run_mode_i != RUN_STOP);
    wire tick      = running && (div_r == div_limit(presc_i[PRM_DIV_LO +: 2]));
    wire rise      = trigger_input_pin_i && !trig_prev_r;
    wire fall      = !trigger_input_pin_i && trig_prev_r;
    wire valid_edge = ((edge_sel == ES_RISE) && rise) || ((edge_sel == ES_FALL) && fall)
                   || ((edge_sel == ES_BOTH) && (rise || fall));
    wire hit_a     = tick && (count_o == cmpa_i);
    wire hit_b     = tick && (count_o == cmpb_i);
    wire clr_trig  = (run_mode_i == RUN_TRIG) && valid_edge;
    wire clr_match = (run_mode_i == RUN_MATCH) && hit_a;
    wire wrap      = tick && (count_o == CNT_MAX);
    wire tog_ev    = toggle_cond_i ? (hit_a || (running && valid_edge)) : (hit_a || hit_b);

    always_comb begin
        if (!running) begin
            count_nxt = WORD_RST;
        end else if (clr_trig || clr_match) begin
            count_nxt = WORD_RST;
        end else if (tick) begin
            count_nxt = count_o + 16'h0001;
        end else begin
            count_nxt = count_o;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            div_r              <= BYTE_RST;
            trig_prev_r        <= 1'b0;
            count_o            <= WORD_RST;
            ovf_flag_o         <= 1'b0;
            timer_output_pin_o <= 1'b0;
            overflow_o         <= 1'b0;
            match_a_o          <= 1'b0;
            match_b_o          <= 1'b0;
        end else begin
            // Prescaler stops with the counter so no count clock reaches it
            div_r       <= (!running || tick) ? BYTE_RST : div_r + 8'h01;
            trig_prev_r <= trigger_input_pin_i;
            count_o     <= count_nxt;
            // Hardware or software set wins over a clear in the same cycle
            if (wrap || ovf_set_i) begin
                ovf_flag_o <= 1'b1;
            end else if (ovf_clr_i || !running) begin
                ovf_flag_o <= 1'b0;
            end
            if (tog_ev) begin
                timer_output_pin_o <= !timer_output_pin_o;
            end
            overflow_o <= wrap;
            match_a_o  <= hit_a;
            match_b_o  <= hit_b;
        end
    end

endmodule

// ==== design/stc_timer_top.sv ====
/*
 Register file, AXI4-Lite slave and interrupt logic around one or two
 16-bit timer/event counters.
 Assumes a single 20 MHz clock, synchronous active-high reset, and trigger
 pins already synchronous to the clock.
*/
// How it works
// - Run-mode 00 stops the timer, its count clock, and zeroes the counter.
// - Run-mode 01 free-runs; 10 restarts on trigger edge; 11 restarts on compare A.
// - Mode register: bits 7..4 zero, run-mode 3..2, toggle bit 1, overflow bit 0.
// - Second timer count is a read-only 16-bit word resetting to zero.
// - Prescaler mode register is read/write and resets to zero.
// - Capture control and output control registers are byte read/write, reset zero.
// - Second timer exists only when program flash is at least 48 KB.
// - Overflow flag sets on wrap from maximum to zero, or by writing one.
// - Prescaler bits 5 and 4 select the valid trigger edge.
module stc_timer_top
    import stc_pkg::*;
#(
    parameter int ADDR_W   = 20,
    parameter int FLASH_KB = 128
)(
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    // Timer pins
    input  wire logic [N_TIMER-1:0] trigger_input_pin_i,
    output logic [N_TIMER-1:0]      timer_output_pin_o,
    output logic [N_TIMER-1:0]      timer_output_en_o,
    output logic                    irq_o
);

    localparam bit HAS_T1 = (FLASH_KB >= T1_MIN_FLASH_KB);

    ////////////////////////////////////////////////////////////////////////
    // Storage

    logic [2:0]       mode_r  [N_TIMER];
    logic [7:0]       presc_r [N_TIMER];
    logic [7:0]       capt_r  [N_TIMER];
    logic [7:0]       outc_r  [N_TIMER];
    logic [15:0]      cmpa_r  [N_TIMER];
    logic [15:0]      cmpb_r  [N_TIMER];
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;

    logic [ADDR_W-1:0] awaddr_r;
    logic              aw_held_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              w_held_r;

    logic [15:0]       count_w   [N_TIMER];
    logic [N_TIMER-1:0] ovf_flag_w;
    logic [N_TIMER-1:0] ovf_ev_w;
    logic [N_TIMER-1:0] mat_a_w;
    logic [N_TIMER-1:0] mat_b_w;
    logic [N_TIMER-1:0] tout_w;
    logic [N_TIMER-1:0] ovf_set_w;
    logic [N_TIMER-1:0] ovf_clr_w;
    logic [IRQ_W-1:0]   irq_ev_w;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic present(input int t);
        present = (t == 0) || HAS_T1;
    endfunction

    function automatic logic [IDX_W-1:0] to_idx(input logic [ADDR_W-1:0] a);
        to_idx = IDX_W'(a >> 2);
    endfunction

    // Register bank of timer t hit by index ix
    function automatic logic [6:0] bank_hits(input logic [IDX_W-1:0] ix, input int t);
        bank_hits = {ix == IDX_CMPB[t], ix == IDX_CMPA[t], ix == IDX_COUNT[t],
                     ix == IDX_OUTC[t], ix == IDX_CAPT[t], ix == IDX_PRESC[t],
                     ix == IDX_MODE[t]} & {7{present(t)}};
    endfunction

    wire [IDX_W-1:0] wr_idx = to_idx(awaddr_r);
    wire [IDX_W-1:0] rd_idx = to_idx(s_axi_araddr_i);
    wire [6:0] wr_hit0 = bank_hits(wr_idx, 0);
    wire [6:0] wr_hit1 = bank_hits(wr_idx, 1);
    wire [6:0] rd_hit0 = bank_hits(rd_idx, 0);
    wire [6:0] rd_hit1 = bank_hits(rd_idx, 1);
    wire [6:0] wr_hit [N_TIMER] = '{wr_hit0, wr_hit1};

    wire wr_stat   = (wr_idx == IDX_IRQ_STAT);
    wire wr_mask   = (wr_idx == IDX_IRQ_MASK);
    wire wr_mapped = (|wr_hit0) || (|wr_hit1) || wr_stat || wr_mask;
    wire rd_stat   = (rd_idx == IDX_IRQ_STAT);
    wire rd_mask   = (rd_idx == IDX_IRQ_MASK);
    wire rd_mapped = (|rd_hit0) || (|rd_hit1) || rd_stat || rd_mask;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes

    // Address and data are taken in either order and held until both arrived
    wire w_fire  = aw_held_r && w_held_r && !s_axi_bvalid_o;
    wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;
    wire lo_en   = w_fire && wstrb_r[0];
    wire hi_en   = w_fire && wstrb_r[1];

    assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held_r && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr_i;
        end else if (w_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            w_held_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata_i;
            wstrb_r  <= s_axi_wstrb_i;
        end else if (w_fire) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end else if (w_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    function automatic logic [31:0] bank_read(input logic [6:0] h, input int t);
        bank_read = '0;
        if (h[0]) bank_read = {28'h0, mode_r[t], ovf_flag_w[t]};
        if (h[1]) bank_read = {24'h0, presc_r[t]};
        if (h[2]) bank_read = {24'h0, capt_r[t]};
        if (h[3]) bank_read = {24'h0, outc_r[t]};
        if (h[4]) bank_read = {16'h0, count_w[t]};
        if (h[5]) bank_read = {16'h0, cmpa_r[t]};
        if (h[6]) bank_read = {16'h0, cmpb_r[t]};
    endfunction

    wire [31:0] rd_irq = rd_stat ? {26'h0, irq_stat_r} : rd_mask ? {26'h0, irq_mask_r} : 32'h0;
    wire [31:0] rd_val = bank_read(rd_hit0, 0) | bank_read(rd_hit1, 1) | rd_irq;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= '0;
            s_axi_rresp_o  <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_val;
            s_axi_rresp_o  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers; count word has no write path

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (int t = 0; t < N_TIMER; t++) begin
                mode_r[t]  <= BYTE_RST[3:1];
                presc_r[t] <= BYTE_RST;
                capt_r[t]  <= BYTE_RST;
                outc_r[t]  <= BYTE_RST;
                cmpa_r[t]  <= WORD_RST;
                cmpb_r[t]  <= WORD_RST;
            end
        end else begin
            for (int t = 0; t < N_TIMER; t++) begin
                if (lo_en && wr_hit[t][0]) begin
                    mode_r[t] <= wdata_r[3:1];
                end
                if (lo_en && wr_hit[t][1]) begin
                    presc_r[t] <= wdata_r[7:0];
                end
                if (lo_en && wr_hit[t][2]) begin
                    capt_r[t] <= wdata_r[7:0];
                end
                if (lo_en && wr_hit[t][3]) begin
                    outc_r[t] <= wdata_r[7:0];
                end
                if (lo_en && wr_hit[t][5]) begin
                    cmpa_r[t][7:0] <= wdata_r[7:0];
                end
                if (hi_en && wr_hit[t][5]) begin
                    cmpa_r[t][15:8] <= wdata_r[15:8];
                end
                if (lo_en && wr_hit[t][6]) begin
                    cmpb_r[t][7:0] <= wdata_r[7:0];
                end
                if (hi_en && wr_hit[t][6]) begin
                    cmpb_r[t][15:8] <= wdata_r[15:8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer instances

    for (genvar t = 0; t < N_TIMER; t++) begin : g_tmr
        assign ovf_set_w[t] = lo_en && wr_hit[t][0] && wdata_r[MODE_OVF_BIT];
        assign ovf_clr_w[t] = lo_en && wr_hit[t][0] && !wdata_r[MODE_OVF_BIT];
        assign irq_ev_w[3*t +: 3] = {mat_b_w[t], mat_a_w[t], ovf_ev_w[t]};

        if (present(t)) begin : g_on
            stc_timer_core u_core (
                .clock_i             (clock_i),
                .sys_rst_i           (sys_rst_i),
                .run_mode_i          (stc_run_e'(mode_r[t][2:1])),
                .toggle_cond_i       (mode_r[t][0]),
                .presc_i             (presc_r[t]),
                .cmpa_i              (cmpa_r[t]),
                .cmpb_i              (cmpb_r[t]),
                .trigger_input_pin_i (trigger_input_pin_i[t]),
                .ovf_set_i           (ovf_set_w[t]),
                .ovf_clr_i           (ovf_clr_w[t]),
                .count_o             (count_w[t]),
                .ovf_flag_o          (ovf_flag_w[t]),
                .timer_output_pin_o  (tout_w[t]),
                .overflow_o          (ovf_ev_w[t]),
                .match_a_o           (mat_a_w[t]),
                .match_b_o           (mat_b_w[t])
            );
        end else begin : g_off
            assign count_w[t]    = WORD_RST;
            assign ovf_flag_w[t] = 1'b0;
            assign tout_w[t]     = 1'b0;
            assign ovf_ev_w[t]   = 1'b0;
            assign mat_a_w[t]    = 1'b0;
            assign mat_b_w[t]    = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins and interrupt

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            timer_output_pin_o <= '0;
            timer_output_en_o  <= '0;
        end else begin
            for (int t = 0; t < N_TIMER; t++) begin
                timer_output_pin_o[t] <= tout_w[t];
                timer_output_en_o[t]  <= outc_r[t][OUTC_EN_BIT] && present(t);
            end
        end
    end

    wire [IRQ_W-1:0] stat_w1c = (lo_en && wr_stat) ? wdata_r[IRQ_W-1:0] : '0;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            irq_stat_r <= IRQ_RST;
            irq_mask_r <= IRQ_RST;
        end else begin
            // New events win over a write-one-to-clear
            irq_stat_r <= (irq_stat_r & ~stat_w1c) | irq_ev_w;
            if (lo_en && wr_mask) begin
                irq_mask_r <= wdata_r[IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule

// ==== tb/stc_timer_top_sva.sv ====
/*
 Checker for stc_timer_top: bus handshakes, read data layout and variant gating.
 Assumes it is bound to every stc_timer_top instance and sees only its ports.
*/
module stc_timer_top_sva
    import stc_pkg::*;
#(
    parameter int ADDR_W   = 20,
    parameter int FLASH_KB = 128
)(
    input wire logic                clock_i,
    input wire logic                sys_rst_i,
    input wire logic                s_axi_awvalid_i,
    input wire logic                s_axi_awready_o,
    input wire logic                s_axi_wvalid_i,
    input wire logic                s_axi_wready_o,
    input wire logic [1:0]          s_axi_bresp_o,
    input wire logic                s_axi_bvalid_o,
    input wire logic                s_axi_bready_i,
    input wire logic [ADDR_W-1:0]   s_axi_araddr_i,
    input wire logic                s_axi_arvalid_i,
    input wire logic                s_axi_arready_o,
    input wire logic [31:0]         s_axi_rdata_o,
    input wire logic [1:0]          s_axi_rresp_o,
    input wire logic                s_axi_rvalid_o,
    input wire logic                s_axi_rready_i,
    input wire logic [N_TIMER-1:0]  timer_output_en_o,
    input wire logic                irq_o
);
    // Second timer answers only in the larger variant
    localparam logic [1:0] T1_RESP = (FLASH_KB >= T1_MIN_FLASH_KB) ? RESP_OKAY : RESP_SLVERR;
    logic [ADDR_W-3:0] rd_idx_r;
    logic              rd_mode;
    logic              rd_t1;
    always_ff @(posedge clock_i) begin
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rd_idx_r <= s_axi_araddr_i[ADDR_W-1:2];
        end
    end
    assign rd_mode = (rd_idx_r == IDX_MODE[0]) || (rd_idx_r == IDX_MODE[1]);
    assign rd_t1   = rd_idx_r inside {IDX_COUNT[1], IDX_CMPA[1], IDX_CMPB[1], IDX_MODE[1],
                                      IDX_PRESC[1], IDX_CAPT[1], IDX_OUTC[1]};
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_b_hold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_rd_answer; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_wr_answer; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o; endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_ar_block; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
    a_ar_block: assert property (p_ar_block) else $error("address taken during pending read");
    property p_upper_zero; s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data upper half not zero");
    property p_mode_hi; s_axi_rvalid_o && rd_mode |-> s_axi_rdata_o[7:4] == 4'h0; endproperty
    a_mode_hi: assert property (p_mode_hi) else $error("mode register high bits not zero");
    property p_variant; s_axi_rvalid_o && rd_t1 |-> s_axi_rresp_o == T1_RESP; endproperty
    a_variant: assert property (p_variant) else $error("second timer response wrong for variant");
    property p_rst_out; $fell(sys_rst_i) |-> timer_output_en_o == '0 && !irq_o; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
    c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
    c_read: cover property (s_axi_rvalid_o && rd_t1);
    c_irq: cover property ($rose(irq_o));
endmodule

bind stc_timer_top stc_timer_top_sva #(.ADDR_W(ADDR_W), .FLASH_KB(FLASH_KB)) i_stc_timer_top_sva (
    .clock_i, .sys_rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .timer_output_en_o, .irq_o);

// ==== tb/stc_timer_top_bench.sv ====
/*
 Self-checking bench for stc_timer_top: register access, run modes, trigger edges,
 toggle output, overflow and interrupt. Assumes default FLASH_KB, both timers present.
*/
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module stc_timer_top_bench
    import stc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i, sys_rst_i, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, irq, tp;
    logic [19:0] awa, ara;
    logic [31:0] wd, rdat, rd_d, rnd;
    logic [3:0]  ws;
    logic [1:0]  br, rr, rsp, trig, tout, ten;
    logic [15:0] c_a, c_b;
    int          err_total, n_compared, seed, tog, n;

    stc_timer_top i_stc_timer_top (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
        .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .trigger_input_pin_i(trig),
        .timer_output_pin_o(tout), .timer_output_en_o(ten), .irq_o(irq));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [17:0] idx, input logic [31:0] d);
        @(posedge clock_i);
        awa <= {idx, 2'b00};
        awv <= 1'b1;
        wd  <= d;
        ws  <= 4'hF;
        wv  <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
        end while (!bv);
        rsp = br;
        bry <= 1'b0;
    endtask
    task automatic rd(input logic [17:0] idx);
        @(posedge clock_i);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        rsp  = rr;
        rd_d = rdat;
        rry <= 1'b0;
    endtask
    task automatic rchk(input logic [17:0] idx, input logic [31:0] e);
        rd(idx);
        `CHK(rsp, RESP_OKAY)
        `CHK(rd_d, e)
    endtask
    function automatic logic exp_clear(input logic [1:0] es, input logic rising);
        return es == ES_BOTH || (rising ? es == ES_RISE : es == ES_FALL);
    endfunction

    initial begin
        repeat (90000) @(posedge clock_i);
        err_total++;
        end_sim;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 8;
        err_total = 0;
        n_compared = 0;
        {awa, ara, wd, ws, awv, wv, bry, arv, rry, trig} = '0;
        sys_rst_i = 1'b1;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        for (int t = 0; t < N_TIMER; t++) begin
            rchk(IDX_MODE[t], 32'h0);
            rchk(IDX_PRESC[t], 32'h0);
            rchk(IDX_CAPT[t], 32'h0);
            rchk(IDX_OUTC[t], 32'h0);
            rchk(IDX_COUNT[t], 32'h0);
            for (int k = 0; k < 3; k++) begin
                rnd = $random(seed);
                wr(IDX_PRESC[t], {24'h0, rnd[7:0]});
                rchk(IDX_PRESC[t], {24'h0, rnd[7:0]});
                wr(IDX_CAPT[t], {24'h0, rnd[15:8]});
                rchk(IDX_CAPT[t], {24'h0, rnd[15:8]});
                wr(IDX_OUTC[t], {24'h0, rnd[23:16]});
                rchk(IDX_OUTC[t], {24'h0, rnd[23:16]});
                `CHK(ten[t], rnd[16])
                wr(IDX_MODE[t], {24'h0, rnd[31:25], 1'b0});
                rchk(IDX_MODE[t], {28'h0, rnd[27:25], 1'b0});
            end
            wr(IDX_MODE[t], 32'h0);
            wr(IDX_PRESC[t], 32'h0);
        end
        // Count must ignore writes and step once per clock at divide by one
        wr(IDX_MODE[1], 32'h04);
        wr(IDX_COUNT[1], 32'h8000);
        `CHK(rsp, RESP_OKAY)
        rd(IDX_COUNT[1]);
        c_a = rd_d[15:0];
        rd(IDX_COUNT[1]);
        c_b = rd_d[15:0];
        `CHK(c_b - c_a, 16'h0003)
        `CHK(c_a < 16'h0100, 1'b1)
        wr(IDX_MODE[1], 32'h0);
        rchk(IDX_COUNT[1], 32'h0);
        rd(18'h00010);
        `CHK(rsp, RESP_SLVERR)
        `CHK(rd_d, 32'h0)
        wr(18'h00010, 32'hFF);
        `CHK(rsp, RESP_SLVERR)
        // Clear on compare A at 0x10, toggles at 0x08 and 0x10: period 17
        wr(IDX_IRQ_STAT, 32'h3F);
        wr(IDX_CMPA[1], 32'h10);
        rchk(IDX_CMPA[1], 32'h10);
        wr(IDX_CMPB[1], 32'h08);
        wr(IDX_MODE[1], 32'h0C);
        repeat (20) @(posedge clock_i);
        tp = tout[1];
        tog = 0;
        for (int i = 0; i < 170; i++) begin
            @(posedge clock_i);
            if (tout[1] !== tp) tog++;
            tp = tout[1];
        end
        `CHK(tog, 20)
        rd(IDX_COUNT[1]);
        `CHK(rd_d[15:0] <= 16'h0010, 1'b1)
        `CHK(irq, 1'b0)
        wr(IDX_IRQ_MASK, 32'h10);
        @(posedge clock_i);
        `CHK(irq, 1'b1)
        wr(IDX_MODE[1], 32'h0);
        rchk(IDX_IRQ_STAT, 32'h30);
        wr(IDX_IRQ_STAT, 32'h10);
        rchk(IDX_IRQ_STAT, 32'h20);
        `CHK(irq, 1'b0)
        for (int e = 0; e < 4; e++) begin
            wr(IDX_PRESC[0], {26'h0, e[1:0], 4'h0});
            wr(IDX_MODE[0], 32'h08);
            repeat (40) @(posedge clock_i);
            trig[0] <= 1'b1;
            repeat (2) @(posedge clock_i);
            rd(IDX_COUNT[0]);
            `CHK(rd_d[15:0] < 16'h0010, exp_clear(e[1:0], 1'b1))
            repeat (40) @(posedge clock_i);
            trig[0] <= 1'b0;
            repeat (2) @(posedge clock_i);
            rd(IDX_COUNT[0]);
            `CHK(rd_d[15:0] < 16'h0010, exp_clear(e[1:0], 1'b0))
            wr(IDX_MODE[0], 32'h0);
        end
        // Full 16-bit wrap is the slow part of the run
        wr(IDX_PRESC[0], 32'h0);
        wr(IDX_IRQ_STAT, 32'h3F);
        wr(IDX_IRQ_MASK, 32'h01);
        wr(IDX_MODE[0], 32'h04);
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clock_i);
            n++;
        end
        `CHK(n > 65000, 1'b1)
        rchk(IDX_MODE[0], 32'h05);
        wr(IDX_MODE[0], 32'h04);
        rchk(IDX_MODE[0], 32'h04);
        wr(IDX_MODE[0], 32'h05);
        rchk(IDX_MODE[0], 32'h05);
        wr(IDX_MODE[0], 32'h00);
        rchk(IDX_MODE[0], 32'h00);
        end_sim;
    end
endmodule
